// ---- pll_synth_pkg.sv ----
// Purpose: Shared constants, field layouts and carriers for the synthesizer
//          divider control block.
// Assumes: Serial words arrive most significant bit first, route bit last.
// Notes:   Every offset, serial field position, setting reset value and count lives here.
`default_nettype none
package pll_synth_pkg;
	// Counter and shift register widths
	localparam int REF_W = 14;
	localparam int MAIN_W = 11;
	localparam int SWAL_W = 7;
	localparam int SHIFT_W = 19;
	localparam int PRE_W = 8;
	// Serial word field positions, route bit is the last bit shifted in
	localparam int ROUTE_POS = 0;
	localparam int REF_LSB = 1;
	localparam int REF_MSB = 17;
	localparam int MAIN_LSB = 1;
	localparam int MAIN_MSB = 18;
	// Prescaler base moduli
	localparam logic [PRE_W-1:0] PRE_MOD_HI = 8'h40;
	localparam logic [PRE_W-1:0] PRE_MOD_LO = 8'h80;
	// Lock window: error limit in reference oscillator periods, regain count in comparisons
	localparam logic [3:0] LOCK_UPPER_OSC = 4'h8;
	localparam logic [1:0] LOCK_GOOD_CYC = 2'h3;
	// Dead-zone correction pulse, mclk cycles per polarity
	localparam logic [2:0] DZ_PULSE_CYC = 3'h2;
	// Restart limiting after power save
	localparam logic [2:0] WARM_COMPARES = 3'h4;
	localparam logic [3:0] WARM_LIMIT_CYC = 4'h4;
	// APB register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] REF_OFS = 8'h08;
	localparam logic [7:0] MAIN_OFS = 8'h0c;
	// Reset values
	localparam logic CTRL_RST = 1'b0;
	localparam logic LOCK_RST = 1'b1;
	localparam logic [REF_W-1:0] REF_RATIO_RST = 14'h0005;
	localparam logic [MAIN_W-1:0] MAIN_CNT_RST = 11'h005;
	localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;

	typedef struct packed {
		logic monitor_select_bit;
		logic phase_polarity_bit;
		logic prescaler_select_bit;
		logic [REF_W-1:0] ref_ratio_bits;
	} ref_cfg_s;

	typedef struct packed {
		logic [MAIN_W-1:0] main_count_bits;
		logic [SWAL_W-1:0] swallow_count_bits;
	} main_cfg_s;

	localparam ref_cfg_s REF_CFG_RST = '{1'b0, 1'b1, 1'b1, REF_RATIO_RST};
	localparam main_cfg_s MAIN_CFG_RST = '{MAIN_CNT_RST, SWAL_RST};

	// Rising edge of a sampled level
	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction
endpackage
`default_nettype wire

// ---- prog_counter.sv ----
// Purpose: Reloading down counter giving one terminal pulse per ratio steps.
// Assumes: Reload value of at least one; new reloads apply at wrap.
// Notes:   Used for the reference and main programmable dividers.
`timescale 1ns/1ps
`default_nettype none
module prog_counter #(
	parameter int W = 14
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic restart,
	input wire logic step,
	input wire logic [W-1:0] reload,
	output logic terminal
);
	import pll_synth_pkg::*;
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// Wrap on the last step so the period is exactly the reload value
	assign terminal = step & ~restart & (cnt_q <= W'(1));
	assign cnt_d = restart ? reload : terminal ? reload :
		step ? cnt_q - W'(1) : cnt_q;

	// Count state
	always_ff @(posedge mclk) begin
		if (!reset_n)
			cnt_q <= W'(5);
		else if (ce)
			cnt_q <= cnt_d;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n || !ce);
	chk_div_wrap: assert property (terminal |=> cnt_q == $past(reload))
		else $error("divider did not reload at wrap");
	chk_div_step: assert property (step && !terminal && !restart
		|=> cnt_q == $past(cnt_q) - W'(1))
		else $error("divider skipped a step");
endmodule // prog_counter
`default_nettype wire

// ---- serial_word_loader.sv ----
// Purpose: Three-wire serial shift register and the two setting latches.
// Assumes: Inputs are already synchronised to mclk and edge-detected.
// Notes:   Not gated by power save, so words load while asleep.
`timescale 1ns/1ps
`default_nettype none
module serial_word_loader (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic sdata,
	input wire logic sclk_rise,
	input wire logic le_rise,
	output pll_synth_pkg::ref_cfg_s ref_cfg,
	output pll_synth_pkg::main_cfg_s main_cfg
);
	import pll_synth_pkg::*;
	logic [SHIFT_W-1:0] shift_q;
	ref_cfg_s ref_q;
	main_cfg_s main_q;
	logic to_ref;
	logic to_main;

	// Latch routing by the last bit shifted in
	assign to_ref = le_rise & shift_q[ROUTE_POS];
	assign to_main = le_rise & ~shift_q[ROUTE_POS];
	assign ref_cfg = ref_q;
	assign main_cfg = main_q;

	always_ff @(posedge mclk) begin
		if (!reset_n)
			shift_q <= '0;
		else if (ce && sclk_rise)
			shift_q <= {shift_q[SHIFT_W-2:0], sdata};
	end

	// Route to reference or main latch
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ref_q <= REF_CFG_RST;
			main_q <= MAIN_CFG_RST;
		end else if (ce) begin
			if (to_ref)
				ref_q <= ref_cfg_s'(shift_q[REF_MSB:REF_LSB]);
			if (to_main)
				main_q <= main_cfg_s'(shift_q[MAIN_MSB:MAIN_LSB]);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n || !ce);
	chk_shift_msb_first: assert property (sclk_rise |=>
		shift_q[0] == $past(sdata)
		&& shift_q[SHIFT_W-1:1] == $past(shift_q[SHIFT_W-2:0]))
		else $error("serial bit not shifted in at the bottom");
	chk_ref_latch_route: assert property (to_ref |=>
		ref_q == $past(shift_q[REF_MSB:REF_LSB]) && $stable(main_q))
		else $error("reference word misrouted");
	chk_main_latch_route: assert property (to_main |=>
		main_q == $past(shift_q[MAIN_MSB:MAIN_LSB]) && $stable(ref_q))
		else $error("main word misrouted");
	cov_ref_load: cover property (to_ref);
	cov_main_load: cover property (to_main);
endmodule // serial_word_loader
`default_nettype wire

// ---- pll_synth_divider_control.sv ----
// Purpose: Digital core of a serially programmed PLL synthesizer: dividers,
//          phase detector, lock detect, power save and register view.
// Assumes: Pin inputs are slow against mclk (at least four mclk per edge).
// Notes:   Charge pump and feedback phase output use out plus active-low enable.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Reference divider ratio is a 14-bit binary value, 5 to 16383.
// - Main divider ratio is an 11-bit binary value, 5 to 2047.
// - Swallow count is 7-bit binary, zero swallows nothing.
// - Prescaler select high gives 64/65, low gives 128/129.
// - Monitor shows divided signal when select high, lock when low.
// - Polarity high: ref leading pumps high, lagging pumps low.
// - Polarity low swaps lead and lag cases; monitor shows feedback.
// - Power save input low stops the loop; high resumes it.
// - After power save, pump error pulses are clamped briefly.
// - Serial words load normally during power save.
// - Pump force input low puts the pump in high impedance.
// - Locked loop still gets short pump pulses to avoid a dead zone.
// - Lock drops at eight oscillator periods of error, returns after three.
// - Lock detect stays high during power save.
// - Serial data shift MSB first; load enable rise latches the word.
// - Route bit high loads reference latch, low the main latch.
// - Feedback ratio is prescaler times main count plus swallow count.
module pll_synth_divider_control (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ser_data,
	input wire logic ser_clk,
	input wire logic load_enable,
	input wire logic power_save_n,
	input wire logic pump_force_n,
	input wire logic ref_osc_input,
	input wire logic vco_fb_input,
	output logic pump_out,
	output logic pump_oe_n,
	output logic phase_ref_out,
	output logic phase_fb_out,
	output logic phase_fb_oe_n,
	output logic monitor_out,
	output logic lock_detect
);
	import pll_synth_pkg::*;

	logic [6:0] pin_raw;
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic [6:0] sync3_q;
	logic sclk_rise, le_rise, osc_rise, vco_rise;
	logic ps_active, ps_release, force_ok;
	ref_cfg_s ref_cfg;
	main_cfg_s main_cfg;
	logic ref_pulse, fb_pulse, pre_term;
	logic [PRE_W-1:0] pre_cnt_q, pre_mod;
	logic [SWAL_W-1:0] swal_q;
	logic up_q, dn_q, both_set, err_one, coincident;
	logic [2:0] dz_q, warm_q;
	logic [3:0] err_len_q, osc_err_q;
	logic dz_up, dz_dn, clamp_ok, up_eff, dn_eff;
	logic fc, drive_hi, drive_lo, pump_en;
	logic big_hit, big_q, good_now;
	logic [1:0] good_q;
	logic lock_q, lock_d, mon_d;
	logic pump_out_q, pump_oe_n_q, phase_ref_q, phase_fb_oe_n_q, monitor_q;
	logic ctrl_pump_off_q;
	logic [31:0] prdata_q;
	logic apb_setup, apb_write, hit_ctrl, hit_status, hit_ref, hit_main;
	logic hit_any;
	logic [31:0] rd_mux;

	// Pin synchronisers; stage one feeds only stage two
	assign pin_raw = {vco_fb_input, ref_osc_input, pump_force_n,
		power_save_n, load_enable, ser_clk, ser_data};
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else if (ce) begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Edge and level decode of the synchronised pins
	assign sclk_rise = rise(sync2_q[1], sync3_q[1]);
	assign le_rise = rise(sync2_q[2], sync3_q[2]);
	assign ps_active = ~sync2_q[3];
	assign ps_release = rise(sync2_q[3], sync3_q[3]);
	assign force_ok = sync2_q[4];
	assign osc_rise = rise(sync2_q[5], sync3_q[5]);
	assign vco_rise = rise(sync2_q[6], sync3_q[6]);

	// Serial port keeps running in power save
	serial_word_loader u_loader (
		.mclk(mclk),
		.reset_n(reset_n),
		.ce(ce),
		.sdata(sync2_q[0]),
		.sclk_rise(sclk_rise),
		.le_rise(le_rise),
		.ref_cfg(ref_cfg),
		.main_cfg(main_cfg)
	);

	// Reference divider; held loaded in power save for aligned restart
	prog_counter #(.W(REF_W)) u_ref_div (
		.mclk(mclk),
		.reset_n(reset_n),
		.ce(ce),
		.restart(ps_active),
		.step(osc_rise),
		.reload(ref_cfg.ref_ratio_bits),
		.terminal(ref_pulse)
	);

	// Prescaler modulus, plus one while swallowing
	// Zero swallow count never adds the extra period
	assign pre_mod = (ref_cfg.prescaler_select_bit ? PRE_MOD_HI : PRE_MOD_LO)
		+ PRE_W'(swal_q != '0);
	assign pre_term = vco_rise & ~ps_active & (pre_cnt_q == pre_mod - PRE_W'(1));

	// Swallow then main count: total is M*N plus A
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pre_cnt_q <= '0;
			swal_q <= SWAL_RST;
		end else if (ce) begin
			if (ps_active || fb_pulse)
				swal_q <= main_cfg.swallow_count_bits;
			else if (pre_term && swal_q != '0)
				swal_q <= swal_q - SWAL_W'(1);
			if (ps_active || pre_term)
				pre_cnt_q <= '0;
			else if (vco_rise)
				pre_cnt_q <= pre_cnt_q + PRE_W'(1);
		end
	end

	// Main counter steps once per prescaler period
	prog_counter #(.W(MAIN_W)) u_main_div (
		.mclk(mclk),
		.reset_n(reset_n),
		.ce(ce),
		.restart(ps_active),
		.step(pre_term),
		.reload(main_cfg.main_count_bits),
		.terminal(fb_pulse)
	);

	// Phase detector flags; a new edge wins over the clear
	assign both_set = up_q & dn_q;
	assign err_one = up_q ^ dn_q;
	assign coincident = ref_pulse & fb_pulse & ~up_q & ~dn_q;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
		end else if (ce) begin
			up_q <= ~ps_active & ((up_q & ~both_set) | ref_pulse);
			dn_q <= ~ps_active & ((dn_q & ~both_set) | fb_pulse);
		end
	end

	// Balanced up/down pair when edges coincide, no dead zone
	assign dz_up = dz_q > DZ_PULSE_CYC;
	assign dz_dn = (dz_q != '0) & (dz_q <= DZ_PULSE_CYC);
	always_ff @(posedge mclk) begin
		if (!reset_n)
			dz_q <= '0;
		else if (ce)
			dz_q <= ps_active ? 3'h0 : coincident ? 3'(DZ_PULSE_CYC * 2) :
				(dz_q != '0) ? dz_q - 3'h1 : dz_q;
	end

	// After wake-up, error pulses clamped for a few comparisons
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			warm_q <= '0;
			err_len_q <= '0;
		end else if (ce) begin
			if (ps_release)
				warm_q <= WARM_COMPARES;
			else if (ref_pulse && warm_q != '0)
				warm_q <= warm_q - 3'h1;
			if (!err_one)
				err_len_q <= '0;
			else if (err_len_q != 4'hf)
				err_len_q <= err_len_q + 4'h1;
		end
	end
	assign clamp_ok = (warm_q == '0) | (err_len_q < WARM_LIMIT_CYC);
	assign up_eff = (up_q & ~dn_q & clamp_ok) | dz_up;
	assign dn_eff = (dn_q & ~up_q & clamp_ok) | dz_dn;

	// Polarity picks which error drives the pump high
	assign fc = ref_cfg.phase_polarity_bit;
	assign drive_hi = fc ? up_eff : dn_eff;
	assign drive_lo = fc ? dn_eff : up_eff;
	// Pump released in power save or when forced off
	assign pump_en = force_ok & ~ps_active & ~ctrl_pump_off_q;

	// Registered pin outputs
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pump_out_q <= 1'b0;
			pump_oe_n_q <= 1'b1;
			phase_ref_q <= 1'b0;
			phase_fb_oe_n_q <= 1'b1;
			monitor_q <= 1'b0;
		end else if (ce) begin
			pump_out_q <= drive_hi;
			pump_oe_n_q <= ~(pump_en & (drive_hi | drive_lo));
			phase_ref_q <= drive_lo;
			phase_fb_oe_n_q <= ~drive_hi;
			monitor_q <= mon_d;
		end
	end

	// Error width in oscillator periods; eight drops lock
	assign big_hit = err_one & osc_rise & (osc_err_q == LOCK_UPPER_OSC - 4'h1);
	assign good_now = ~big_q & ~big_hit;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			osc_err_q <= '0;
			big_q <= 1'b0;
			good_q <= '0;
		end else if (ce) begin
			if (!err_one)
				osc_err_q <= '0;
			else if (osc_rise && osc_err_q != 4'hf)
				osc_err_q <= osc_err_q + 4'h1;
			big_q <= big_hit | (big_q & ~ref_pulse);
			if (ps_active || (ref_pulse && !good_now))
				good_q <= '0;
			else if (ref_pulse && good_q != LOCK_GOOD_CYC)
				good_q <= good_q + 2'h1;
		end
	end

	// Lock forced high in power save
	// Three clean comparisons in a row bring lock back
	assign lock_d = ps_active ? 1'b1 : big_hit ? 1'b0 :
		(ref_pulse & good_now & (good_q == LOCK_GOOD_CYC - 2'h1)) ? 1'b1 :
		lock_q;
	always_ff @(posedge mclk) begin
		if (!reset_n)
			lock_q <= LOCK_RST;
		else if (ce)
			lock_q <= lock_d;
	end

	// Monitor: divided signal chosen by polarity, or lock
	assign mon_d = ref_cfg.monitor_select_bit ?
		(fc ? ref_pulse : fb_pulse) : lock_q;

	// APB decode; zero wait states, read data captured in setup
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign hit_ctrl = paddr == CTRL_OFS;
	assign hit_status = paddr == STATUS_OFS;
	assign hit_ref = paddr == REF_OFS;
	assign hit_main = paddr == MAIN_OFS;
	assign hit_any = hit_ctrl | hit_status | hit_ref | hit_main;
	assign rd_mux = hit_ctrl ? {31'h0, ctrl_pump_off_q} :
		hit_status ? {29'h0, warm_q != '0, ps_active, lock_q} :
		hit_ref ? {15'h0, ref_cfg} :
		hit_main ? {14'h0, main_cfg} : 32'h0;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrl_pump_off_q <= CTRL_RST;
			prdata_q <= '0;
		end else if (ce) begin
			if (apb_write && hit_ctrl)
				ctrl_pump_off_q <= pwdata[0];
			if (apb_setup && !pwrite)
				prdata_q <= rd_mux;
		end
	end

	// Port drive
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_any;
	assign prdata = prdata_q;
	assign pump_out = pump_out_q;
	assign pump_oe_n = pump_oe_n_q;
	assign phase_ref_out = phase_ref_q;
	assign phase_fb_out = 1'b0;
	assign phase_fb_oe_n = phase_fb_oe_n_q;
	assign monitor_out = monitor_q;
	assign lock_detect = lock_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n || !ce);
	chk_ps_lock_high: assert property (ps_active |=> lock_detect)
		else $error("lock low during power save");
	chk_ps_pump_off: assert property (ps_active |=> pump_oe_n [*2])
		else $error("pump driven in power save");
	chk_force_pump_z: assert property (!force_ok |=> pump_oe_n)
		else $error("pump driven while forced off");
	chk_fc_high_lead: assert property (fc && up_eff && !dn_eff && pump_en
		|=> pump_out && !pump_oe_n && !phase_ref_out && !phase_fb_oe_n)
		else $error("wrong drive for leading reference");
	chk_fc_low_lead: assert property (!fc && up_eff && !dn_eff && pump_en
		|=> !pump_out && !pump_oe_n && phase_ref_out && phase_fb_oe_n)
		else $error("polarity low not swapped");
	chk_dz_pulse_pair: assert property (coincident && !ps_active
		|=> dz_up [*2] ##1 dz_dn [*2] ##1 dz_q == 3'h0)
		else $error("dead-zone pulse pair malformed");
	chk_unlock_window: assert property (big_hit && !ps_active
		|=> !lock_detect)
		else $error("lock held through large error");
	chk_lock_monitor: assert property (!ref_cfg.monitor_select_bit
		|=> monitor_out == $past(lock_q))
		else $error("monitor not showing lock");
	chk_prescale_wrap: assert property (pre_term |-> pre_cnt_q ==
		(ref_cfg.prescaler_select_bit ? 8'h3f : 8'h7f) + PRE_W'(swal_q != '0))
		else $error("prescaler wrapped at wrong count");
	chk_wake_clamp: assert property (warm_q != '0 && dz_q == '0
		&& err_len_q >= WARM_LIMIT_CYC |=> pump_oe_n && !phase_ref_out)
		else $error("error pulse not clamped after wake-up");
	cov_lock_regained: cover property (!lock_q ##1 lock_q);
	cov_ps_release: cover property (ps_release);
	cov_dz_pair: cover property (coincident);
	cov_unlock: cover property (big_hit);
endmodule // pll_synth_divider_control
`default_nettype wire

// ---- serial_host_model.sv ----
// Purpose: Host controller model that loads serial words into the block.
// Assumes: Serial clock period 125 ns; clock idles low between frames.
// Notes:   No pull on the data line, so it shows the inverted last bit.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	output logic ser_data,
	output logic ser_clk,
	output logic load_enable
);
	// Idle levels at time zero
	initial begin
		ser_data = 1'b0;
		ser_clk = 1'b0;
		load_enable = 1'b0;
	end

	// One frame: n bits, then a load pulse; data held until after the pulse
	task automatic send(input logic [18:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			ser_data = w[i];
			#62.5 ser_clk = 1'b1;
			#62.5 ser_clk = 1'b0;
		end
		#62.5 load_enable = 1'b1;
		#62.5 load_enable = 1'b0;
		ser_data = ~w[0]; // Stale bit must not look valid
		// Idle gap so a following frame never redrives data at once
		#62.5;
	endtask
endmodule // serial_host_model
`default_nettype wire

// ---- pll_synth_divider_control_tb.sv ----
// Purpose: Self-checking bench for the synthesizer divider control block.
// Assumes: Oscillator 96 ns and VCO 64 ns, both slow against mclk.
// Notes:   Loop checks count pump and monitor cycles over fixed windows.
`timescale 1ns/1ps
`default_nettype none
module pll_synth_divider_control_tb;
	import pll_synth_pkg::*;
	localparam int WIN = 15360;
	logic mclk, reset_n, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic power_save_n, pump_force_n, osc, vco, er;
	wire ser_data, ser_clk, load_enable;
	logic pump_out, pump_oe_n, phase_ref_out, phase_fb_out, phase_fb_oe_n;
	logic monitor_out, lock_detect;
	int num_errors, check_count, hi_n, lo_n, mon_n, lock_lo_n, pr_n, pf_n;

	pll_synth_divider_control u_pll_synth_divider_control (
		.mclk(mclk), .reset_n(reset_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ser_data(ser_data), .ser_clk(ser_clk), .load_enable(load_enable),
		.power_save_n(power_save_n), .pump_force_n(pump_force_n),
		.ref_osc_input(osc), .vco_fb_input(vco), .pump_out(pump_out),
		.pump_oe_n(pump_oe_n), .phase_ref_out(phase_ref_out),
		.phase_fb_out(phase_fb_out), .phase_fb_oe_n(phase_fb_oe_n),
		.monitor_out(monitor_out), .lock_detect(lock_detect)
	);

	serial_host_model u_serial_host_model (
		.ser_data(ser_data), .ser_clk(ser_clk), .load_enable(load_enable)
	);

	// System clock, 8 ns period
	always #4 mclk = ~mclk;

	// Oscillator and VCO, phase offset so edges avoid mclk edges
	initial begin
		osc = 1'b0;
		vco = 1'b0;
		#3;
		fork
			forever #48 osc = ~osc;
			forever #32 vco = ~vco;
		join
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Counts allow one pulse of slack for synchroniser jitter
	task automatic near(input int got, input int exp);
		check_count++;
		if (got < exp - 1 || got > exp + 1) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; result left in rd and er
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Sample settled outputs at the falling edge for n cycles
	task automatic observe(input int n);
		hi_n = 0;
		lo_n = 0;
		mon_n = 0;
		lock_lo_n = 0;
		pr_n = 0;
		pf_n = 0;
		repeat (n) begin
			@(negedge mclk);
			if (phase_ref_out === 1'b1) pr_n++;
			if (phase_fb_oe_n === 1'b0 && phase_fb_out === 1'b0) pf_n++;
			if (pump_oe_n === 1'b0 && pump_out === 1'b1) hi_n++;
			if (pump_oe_n === 1'b0 && pump_out === 1'b0) lo_n++;
			if (monitor_out === 1'b1) mon_n++;
			if (lock_detect === 1'b0) lock_lo_n++;
		end
	endtask

	function automatic logic [18:0] ref_word(input logic fc, input logic sw);
		return {1'b0, 1'b1, fc, sw, 14'd320, 1'b1};
	endfunction

	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog, run needs about 75000 cycles
	initial begin
		repeat (95000) @(posedge mclk);
		num_errors++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		power_save_n = 1'b0; // held low at power-on
		pump_force_n = 1'b1;
		num_errors = 0;
		check_count = 0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, STATUS_OFS, 32'h0);
		check(rd, 32'h3);
		apb(1'b0, REF_OFS, 32'h0);
		check(rd, 32'h0000c005);
		apb(1'b0, MAIN_OFS, 32'h0);
		check(rd, 32'h00000280);
		apb(1'b0, 8'h10, 32'h0);
		check({rd[30:0], er}, 32'h1);
		apb(1'b1, CTRL_OFS, 32'h1);
		apb(1'b1, REF_OFS, 32'hffffffff);
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, REF_OFS, 32'h0);
		check(rd, 32'h0000c005);
		apb(1'b1, CTRL_OFS, 32'h0);
		// Words load while asleep; ratios kept at five or more
		u_serial_host_model.send(ref_word(1'b1, 1'b1), 18);
		u_serial_host_model.send({11'd5, 7'd3, 1'b0}, 19);
		repeat (40) @(posedge mclk);
		apb(1'b0, REF_OFS, 32'h0);
		check(rd, 32'h0001c140);
		apb(1'b0, MAIN_OFS, 32'h0);
		check(rd, 32'h00000283);
		observe(2000);
		check(hi_n + lo_n + lock_lo_n + pr_n + pf_n, 32'h0);
		@(posedge mclk);
		power_save_n <= 1'b1;
		repeat (8) @(posedge mclk);
		apb(1'b0, STATUS_OFS, 32'h0);
		check(rd & 32'h6, 32'h4);
		repeat (20000) @(posedge mclk);
		// Feedback faster than reference, polarity high
		observe(WIN);
		check(32'(lo_n > hi_n), 32'h1);
		check(32'(lock_lo_n > 0), 32'h1);
		check(32'(pr_n > pf_n), 32'h1);
		near(mon_n, WIN / (320 * 12));
		@(posedge mclk);
		pump_force_n <= 1'b0;
		// Pin passes two sync stages and the output register first
		repeat (4) @(posedge mclk);
		observe(2000);
		check(hi_n + lo_n, 32'h0);
		// Register off before the pin lets go, so no drive slips through
		apb(1'b1, CTRL_OFS, 32'h1);
		@(posedge mclk);
		pump_force_n <= 1'b1;
		observe(2000);
		check(hi_n + lo_n, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0);
		u_serial_host_model.send(ref_word(1'b0, 1'b1), 18);
		observe(WIN);
		check(32'(hi_n > lo_n), 32'h1);
		check(32'(pf_n > pr_n), 32'h1);
		near(mon_n, WIN / ((64 * 5 + 3) * 8));
		u_serial_host_model.send(ref_word(1'b0, 1'b0), 18);
		observe(WIN);
		near(mon_n, WIN / ((128 * 5 + 3) * 8));
		report_and_stop();
	end
endmodule // pll_synth_divider_control_tb
`default_nettype wire
